/* cdm_decoder.sv */
`default_nettype none
module cdm_decoder (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	input wire logic prot_mode,
	input wire logic opsize32,
	output logic byte_ready,
	output logic busy,
	output logic done,
	output cdm_pkg::cdm_result_t result
);
	import cdm_pkg::*;

	typedef enum logic [2:0] {
		ST_FETCH, ST_ESCAPE, ST_MODRM, ST_TRAIL, ST_EXEC
	} cdm_state_t;

	cdm_state_t state;
	cdm_state_t next_state;
	cdm_result_t next_res;
	logic [2:0] next_trail;
	logic [2:0] trail;
	logic [4:0] cnt;
	logic take;

	// ==========================================================
	// byte intake
	assign byte_ready = (state != ST_EXEC);
	assign busy = (state == ST_EXEC);
	assign take = byte_valid && byte_ready;

	// decode of the byte being taken in the current state
	always_comb begin
		next_state = state;
		next_res = result;
		next_trail = trail;
		unique case (state)
			ST_FETCH: begin
				next_res = RESULT_RESET;
				next_res.clocks = CLK_SINGLE;
				next_res.width_bit = byte_data[0];
				next_trail = 3'h0;
				next_state = ST_EXEC;
				if (byte_data == OPC_ESCAPE) begin
					next_state = ST_ESCAPE;
				end else if (byte_data == OPC_FRAME_TEARDOWN) begin
					next_res.op = CDM_OP_FRAME_TEARDOWN;
					next_res.clocks = CLK_FRAME_TEARDOWN;
				end else if (byte_data == OPC_BRANCH_COUNT) begin
					next_res.op = CDM_OP_BRANCH_COUNT;
				end else if (byte_data == OPC_BRANCH_NZ) begin
					next_res.op = CDM_OP_BRANCH_NZ;
				end else if (byte_data == OPC_BRANCH_Z) begin
					next_res.op = CDM_OP_BRANCH_Z;
				end else if (byte_data[7:4] == NIB_IMM_SHORT) begin
					// width bit is bit 3, register in the low three bits
					next_res.op = CDM_OP_IMM_TO_REG;
					next_res.width_bit = byte_data[3];
					next_res.reg_field = byte_data[2:0];
					next_trail = (byte_data[3] ? TRAIL_FULL : TRAIL_IMM_BYTE);
				end else if (byte_data[7:4] == NIB_ACC_SHORT &&
						byte_data[3:1] == PAT_MEM_TO_ACC) begin
					next_res.op = CDM_OP_MEM_TO_ACC;
					next_trail = TRAIL_FULL;
				end else if (byte_data[7:4] == NIB_ACC_SHORT &&
						byte_data[3:1] == PAT_ACC_TO_MEM) begin
					next_res.op = CDM_OP_ACC_TO_MEM;
					next_trail = TRAIL_FULL;
				end else if (byte_data == OPC_SEG_LOAD) begin
					next_res.op = CDM_OP_SEG_LOAD;
					next_state = ST_MODRM;
				end else if (byte_data == OPC_SEG_STORE) begin
					next_res.op = CDM_OP_SEG_STORE;
					next_state = ST_MODRM;
				end else if (byte_data[7:1] == OPC_UNARY_GRP) begin
					next_res.xop = CDM_XOP_PRODUCT;
					next_state = ST_MODRM;
				end else begin
					next_res.illegal = 1'b1;
				end
				// short offset follows each counted branch
				if (next_res.op == CDM_OP_BRANCH_COUNT || next_res.op == CDM_OP_BRANCH_NZ ||
						next_res.op == CDM_OP_BRANCH_Z) begin
					next_res.clocks = CLK_BRANCH;
					next_trail = TRAIL_SHORT_OFS;
				end
				if (next_trail != 3'h0) begin
					next_state = ST_TRAIL;
				end
			end
			ST_ESCAPE: begin
				next_state = ST_MODRM;
				next_res.width_bit = byte_data[0];
				unique case (byte_data)
					ESC_CTRL_WR: next_res.op = CDM_OP_CTRL_WR;
					ESC_CTRL_RD: next_res.op = CDM_OP_CTRL_RD;
					ESC_DBG_WR: next_res.op = CDM_OP_DBG_WR;
					ESC_DBG_RD: next_res.op = CDM_OP_DBG_RD;
					ESC_TEST_WR: next_res.op = CDM_OP_TEST_WR;
					ESC_TEST_RD: next_res.op = CDM_OP_TEST_RD;
					default: begin
						if (byte_data[7:1] == ESC_SIGN_WIDEN) begin
							next_res.xop = CDM_XOP_SIGN_WIDEN;
						end else if (byte_data[7:1] == ESC_ZERO_WIDEN) begin
							next_res.xop = CDM_XOP_ZERO_WIDEN;
						end else begin
							next_res.illegal = 1'b1;
							next_state = ST_EXEC;
						end
					end
				endcase
			end
			ST_MODRM: begin
				// special register moves carry eee in bits 5:3, widens carry reg
				next_res.reg_field = byte_data[5:3];
				next_state = ST_EXEC;
				unique case (result.op)
					CDM_OP_SEG_LOAD: begin
						next_res.clocks = prot_mode ? CLK_SEG_LOAD_PROT : CLK_SINGLE;
					end
					CDM_OP_SEG_STORE: next_res.clocks = CLK_SINGLE;
					CDM_OP_CTRL_WR: begin
						unique case (byte_data[5:3])
							3'h0: next_res.clocks = prot_mode ? CLK_CR0_WR_PROT : CLK_CR0_WR_REAL;
							3'h2, 3'h3: next_res.clocks = CLK_CR3_WR;
							3'h4: next_res.clocks = prot_mode ? CLK_CR4_WR_PROT : CLK_CR4_WR_REAL;
							default: next_res.illegal = 1'b1;
						endcase
					end
					CDM_OP_CTRL_RD: begin
						next_res.clocks = CLK_CTRL_RD;
						next_res.illegal = !(byte_data[5:3] == 3'h0 || byte_data[5:3] == 3'h2 ||
							byte_data[5:3] == 3'h3 || byte_data[5:3] == 3'h4);
					end
					CDM_OP_DBG_WR, CDM_OP_DBG_RD: begin
						// locations 0..3 and status 6..7 only
						next_res.clocks = (result.op == CDM_OP_DBG_WR) ? CLK_DBG_WR : CLK_DBG_RD;
						next_res.illegal = (byte_data[5:3] == 3'h4 || byte_data[5:3] == 3'h5);
					end
					CDM_OP_TEST_WR: begin
						next_res.clocks = (byte_data[5:4] == 2'h3) ? CLK_TLB_TEST_WR : CLK_CACHE_TEST_WR;
						next_res.illegal = (byte_data[5:3] < 3'h3);
					end
					CDM_OP_TEST_RD: begin
						next_res.clocks = (byte_data[5:4] == 2'h3) ? CLK_TLB_TEST_RD : CLK_CACHE_TEST_RD;
						next_res.illegal = (byte_data[5:3] < 3'h3);
					end
					default: begin
						if (result.xop == CDM_XOP_PRODUCT) begin
							// only reg field 100 of the unary group is handled here
							next_res.illegal = (byte_data[5:3] != REG_UNSIGNED_PRODUCT);
							if (!result.width_bit) begin
								next_res.clocks = CLK_PRODUCT_BYTE;
							end else begin
								next_res.clocks = opsize32 ? CLK_PRODUCT_DWORD : CLK_PRODUCT_WORD;
							end
							next_res.flags_kept = 1'b0;
						end else begin
							next_res.clocks = CLK_SINGLE;
						end
					end
				endcase
			end
			ST_TRAIL: begin
				next_trail = trail - 3'h1;
				if (trail == 3'h1) begin
					next_state = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (cnt == 5'h01) begin
					next_state = ST_FETCH;
				end
			end
		endcase
	end

	// ==========================================================
	// sequencing; only a taken byte advances the intake states
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_FETCH;
		end else if (take || state == ST_EXEC) begin
			state <= next_state;
		end
	end

	// decoded result held until the next instruction starts
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			result <= RESULT_RESET;
			trail <= 3'h0;
		end else if (take) begin
			result <= next_res;
			trail <= next_trail;
		end
	end

	// execution counter, loaded from the decoded clock count on entry
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 5'h00;
		end else if (take && next_state == ST_EXEC) begin
			cnt <= next_res.clocks;
		end else if (state == ST_EXEC) begin
			cnt <= cnt - 5'h01;
		end
	end

	assign done = (state == ST_EXEC) && (cnt == 5'h01);

	// ==========================================================
	// checks; elapsed counts cycles spent in execution
	logic [4:0] elapsed;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			elapsed <= 5'h00;
		end else if (state == ST_EXEC && !done) begin
			elapsed <= elapsed + 5'h01;
		end else begin
			elapsed <= 5'h00;
		end
	end

	chk_exec_length: assert property (@(posedge clk_sys) disable iff (!rst_n)
		done |-> (elapsed + 5'h01 == result.clocks))
		else $error("execution length differs from decoded clocks");
	chk_teardown_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
		done && result.op == CDM_OP_FRAME_TEARDOWN |-> result.clocks == 5'h04 &&
		result.flags_kept)
		else $error("frame teardown timing wrong");
	// anchored on the offset byte, so a slow fetch stage between the bytes is legal
	chk_branch_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state == ST_TRAIL && take && result.op inside {CDM_OP_BRANCH_COUNT,
		CDM_OP_BRANCH_NZ, CDM_OP_BRANCH_Z}) |=>
		(state == ST_EXEC) [*2] ##1 state == ST_FETCH)
		else $error("counted branch sequence wrong");
	chk_imm_trail: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state == ST_FETCH && take && byte_data[7:3] == 5'h17) |=>
		trail == 3'h4 && result.op == CDM_OP_IMM_TO_REG)
		else $error("short immediate wide form trail wrong");
	chk_acc_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state == ST_FETCH && take && byte_data == 8'hA1) |=>
		result.op == CDM_OP_MEM_TO_ACC && trail == 3'h4 && result.clocks == 5'h01)
		else $error("memory to accumulator decode wrong");
	chk_acc_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state == ST_FETCH && take && byte_data == 8'hA2) |=>
		result.op == CDM_OP_ACC_TO_MEM && trail == 3'h4)
		else $error("accumulator to memory decode wrong");
	chk_seg_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state == ST_MODRM && take && result.op == CDM_OP_SEG_LOAD) |=>
		result.clocks == ($past(prot_mode) ? 5'h06 : 5'h01))
		else $error("segment load timing wrong");
	chk_seg_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
		done && result.op == CDM_OP_SEG_STORE |-> $past(state) == ST_MODRM)
		else $error("segment store not one clock");
	chk_cr0_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state == ST_MODRM && take && result.op == CDM_OP_CTRL_WR && byte_data[5:3] == 3'h0)
		|=> result.clocks == ($past(prot_mode) ? 5'h12 : 5'h14))
		else $error("first control register write timing wrong");
	chk_widen_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
		done && result.xop inside {CDM_XOP_SIGN_WIDEN, CDM_XOP_ZERO_WIDEN} |->
		result.flags_kept && result.clocks == 5'h01)
		else $error("widen transfer timing or flags wrong");
	// operand size is judged as it stood when the mode byte was taken
	chk_product_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state == ST_MODRM && take && result.xop == CDM_XOP_PRODUCT) |=>
		result.clocks == (!result.width_bit ? 5'h04 :
		($past(opsize32) ? 5'h0F : 5'h05)))
		else $error("unsigned product timing wrong");
	chk_debug_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
		done && result.op == CDM_OP_DBG_WR |-> result.clocks == 5'h0A)
		else $error("debug write timing wrong");
endmodule
`default_nettype wire

/* cdm_fetch_model.sv */
`default_nettype none
// ==========================================================
// fetch stage model: offers queued instruction bytes, optionally with idle gaps
module cdm_fetch_model (
	input wire logic clk_sys,
	input wire logic byte_ready,
	output logic byte_valid,
	output logic [7:0] byte_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] queue_bytes[$];
	int gap = 0;
	int n_taken = 0;
	int idle = 0;
	logic taken = 1'b0;
	initial begin
		byte_valid = 1'b0;
		byte_data = 8'h00;
	end
	// handshake seen at the rising edge, before the design's own updates land
	always @(posedge clk_sys) begin
		taken = byte_valid && byte_ready;
		if (taken) begin
			n_taken++;
		end
	end
	// offer on the falling edge; an idle line toggles so a stale byte never looks fresh
	always @(negedge clk_sys) begin
		if (taken) begin
			void'(queue_bytes.pop_front());
			idle = gap;
		end
		if ((taken || !byte_valid) && queue_bytes.size() > 0 && idle == 0) begin
			byte_valid = 1'b1;
			byte_data = queue_bytes[0];
		end else if (taken || !byte_valid) begin
			byte_valid = 1'b0;
			byte_data = ~byte_data;
			if (idle > 0) begin
				idle--;
			end
		end
		taken = 1'b0;
	end
endmodule
`default_nettype wire

/* cdm_pkg.sv */
`default_nettype none
package cdm_pkg;
	// ==========================================================
	// opcode bytes
	localparam logic [7:0] OPC_ESCAPE = 8'h0F;
	localparam logic [7:0] OPC_FRAME_TEARDOWN = 8'hC9;
	localparam logic [7:0] OPC_BRANCH_COUNT = 8'hE2;
	localparam logic [7:0] OPC_BRANCH_NZ = 8'hE0;
	localparam logic [7:0] OPC_BRANCH_Z = 8'hE1;
	localparam logic [3:0] NIB_IMM_SHORT = 4'hB;
	localparam logic [3:0] NIB_ACC_SHORT = 4'hA;
	localparam logic [2:0] PAT_MEM_TO_ACC = 3'h0;
	localparam logic [2:0] PAT_ACC_TO_MEM = 3'h1;
	localparam logic [7:0] OPC_SEG_LOAD = 8'h8E;
	localparam logic [7:0] OPC_SEG_STORE = 8'h8C;
	localparam logic [6:0] OPC_UNARY_GRP = 7'h7B;
	localparam logic [2:0] REG_UNSIGNED_PRODUCT = 3'h4;
	// second byte after escape
	localparam logic [7:0] ESC_CTRL_WR = 8'h22;
	localparam logic [7:0] ESC_CTRL_RD = 8'h20;
	localparam logic [7:0] ESC_DBG_WR = 8'h23;
	localparam logic [7:0] ESC_DBG_RD = 8'h21;
	localparam logic [7:0] ESC_TEST_WR = 8'h26;
	localparam logic [7:0] ESC_TEST_RD = 8'h24;
	localparam logic [6:0] ESC_SIGN_WIDEN = 7'h5F;
	localparam logic [6:0] ESC_ZERO_WIDEN = 7'h5B;
	// trailing byte counts
	localparam logic [2:0] TRAIL_SHORT_OFS = 3'h1;
	localparam logic [2:0] TRAIL_IMM_BYTE = 3'h1;
	localparam logic [2:0] TRAIL_FULL = 3'h4;
	// ==========================================================
	// execution clock counts (cache hit)
	localparam logic [4:0] CLK_FRAME_TEARDOWN = 5'h04;
	localparam logic [4:0] CLK_BRANCH = 5'h02;
	localparam logic [4:0] CLK_SINGLE = 5'h01;
	localparam logic [4:0] CLK_SEG_LOAD_PROT = 5'h06;
	localparam logic [4:0] CLK_CR0_WR_REAL = 5'h14;
	localparam logic [4:0] CLK_CR0_WR_PROT = 5'h12;
	localparam logic [4:0] CLK_CR3_WR = 5'h05;
	localparam logic [4:0] CLK_CR4_WR_REAL = 5'h05;
	localparam logic [4:0] CLK_CR4_WR_PROT = 5'h06;
	localparam logic [4:0] CLK_CTRL_RD = 5'h06;
	localparam logic [4:0] CLK_DBG_WR = 5'h0A;
	localparam logic [4:0] CLK_DBG_RD = 5'h09;
	localparam logic [4:0] CLK_CACHE_TEST_WR = 5'h10;
	localparam logic [4:0] CLK_CACHE_TEST_RD = 5'h08;
	localparam logic [4:0] CLK_TLB_TEST_WR = 5'h0B;
	localparam logic [4:0] CLK_TLB_TEST_RD = 5'h03;
	localparam logic [4:0] CLK_PRODUCT_BYTE = 5'h04;
	localparam logic [4:0] CLK_PRODUCT_WORD = 5'h05;
	localparam logic [4:0] CLK_PRODUCT_DWORD = 5'h0F;
	// ==========================================================
	typedef enum logic [3:0] {
		CDM_OP_NONE, CDM_OP_FRAME_TEARDOWN, CDM_OP_BRANCH_COUNT,
		CDM_OP_BRANCH_NZ, CDM_OP_BRANCH_Z, CDM_OP_IMM_TO_REG,
		CDM_OP_MEM_TO_ACC, CDM_OP_ACC_TO_MEM, CDM_OP_SEG_LOAD,
		CDM_OP_SEG_STORE, CDM_OP_CTRL_WR, CDM_OP_CTRL_RD, CDM_OP_DBG_WR,
		CDM_OP_DBG_RD, CDM_OP_TEST_WR, CDM_OP_TEST_RD
	} cdm_op_t;
	typedef enum logic [1:0] {
		CDM_XOP_NONE, CDM_XOP_SIGN_WIDEN, CDM_XOP_ZERO_WIDEN, CDM_XOP_PRODUCT
	} cdm_xop_t;
	typedef struct packed {
		cdm_op_t op;
		cdm_xop_t xop;
		logic illegal;
		logic flags_kept;
		logic width_bit;
		logic [2:0] reg_field;
		logic [4:0] clocks;
	} cdm_result_t;
	localparam cdm_result_t RESULT_RESET = '{CDM_OP_NONE, CDM_XOP_NONE, 1'b0, 1'b1,
		1'b0, 3'h0, 5'h00};
endpackage
`default_nettype wire

/* cdm_tb.sv */
`default_nettype none
module testbench;
	import cdm_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic prot_mode = 1'b0;
	logic opsize32 = 1'b0;
	wire logic byte_valid;
	wire logic [7:0] byte_data;
	logic byte_ready;
	logic busy;
	logic done;
	cdm_result_t result;
	int failures = 0;
	int n_tests = 0;
	int expect_taken = 0;
	int lens[$];

	// ==========================================================
	// clock and instances
	always #2.5 clk_sys = ~clk_sys;
	cdm_decoder uut (.clk_sys(clk_sys), .rst_n(rst_n), .byte_valid(byte_valid),
		.byte_data(byte_data), .prot_mode(prot_mode), .opsize32(opsize32),
		.byte_ready(byte_ready), .busy(busy), .done(done), .result(result));
	cdm_fetch_model fetch (.clk_sys(clk_sys), .byte_ready(byte_ready),
		.byte_valid(byte_valid), .byte_data(byte_data));

	// ==========================================================
	// shared tasks
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) fetch.queue_bytes.push_back(b[i]);
		// one send is one instruction, so each check knows where its bytes end
		lens.push_back(b.size());
	endtask
	// waits for the last byte, then counts execution cycles up to done
	task automatic check_exec(input int n, input cdm_op_t op, input cdm_xop_t xop,
		input logic kept, input logic bad = 1'b0);
		int k;
		k = 0;
		expect_taken += lens.pop_front();
		do begin
			@(negedge clk_sys);
			k++;
		end while (fetch.n_taken < expect_taken && k < 200);
		if (k >= 200) begin
			failures++;
			complete_run();
		end
		for (k = 1; k < 30; k++) begin
			check_val("busy", 8'h01, {7'h00, busy});
			check_val("ready", 8'h00, {7'h00, byte_ready});
			if (done === 1'b1) begin
				break;
			end
			@(negedge clk_sys);
		end
		if (k >= 30) begin
			failures++;
			complete_run();
		end
		check_val("exec clocks", 8'(n), 8'(k));
		check_val("clocks field", 8'(n), {3'h0, result.clocks});
		check_val("flags kept", {7'h00, kept}, {7'h00, result.flags_kept});
		check_val("illegal", {7'h00, bad}, {7'h00, result.illegal});
		if (xop == CDM_XOP_NONE) begin
			check_val("op", {4'h0, op}, {4'h0, result.op});
		end else begin
			check_val("xop", {6'h00, xop}, {6'h00, result.xop});
		end
	endtask

	// ==========================================================
	// scenarios
	task automatic sc_teardown_branch();
		for (int m = 0; m < 2; m++) begin
			prot_mode = m[0];
			send({8'hC9});
			check_exec(4, CDM_OP_FRAME_TEARDOWN, CDM_XOP_NONE, 1'b1);
		end
		// all three queued at once so each follows the previous back to back
		send({8'hE2, 8'h5A});
		send({8'hE0, 8'h80});
		send({8'hE1, 8'h7F});
		check_exec(2, CDM_OP_BRANCH_COUNT, CDM_XOP_NONE, 1'b1);
		check_exec(2, CDM_OP_BRANCH_NZ, CDM_XOP_NONE, 1'b1);
		check_exec(2, CDM_OP_BRANCH_Z, CDM_XOP_NONE, 1'b1);
	endtask
	task automatic sc_short_forms();
		send({8'hBB, 8'h11, 8'h22, 8'h33, 8'h44});
		check_exec(1, CDM_OP_IMM_TO_REG, CDM_XOP_NONE, 1'b1);
		check_val("width", 8'h01, {7'h00, result.width_bit});
		check_val("reg", 8'h03, {5'h00, result.reg_field});
		send({8'hB1, 8'h55});
		check_exec(1, CDM_OP_IMM_TO_REG, CDM_XOP_NONE, 1'b1);
		check_val("width", 8'h00, {7'h00, result.width_bit});
		check_val("reg", 8'h01, {5'h00, result.reg_field});
		for (int i = 0; i < 4; i++) begin
			send({8'hA0 | 8'(i), 8'h01, 8'h02, 8'h03, 8'h04});
			check_exec(1, (i < 2) ? CDM_OP_MEM_TO_ACC : CDM_OP_ACC_TO_MEM, CDM_XOP_NONE,
				1'b1);
		end
	endtask
	task automatic sc_segment_control();
		for (int m = 0; m < 2; m++) begin
			prot_mode = m[0];
			send({8'h8E, 8'hD8});
			check_exec(m ? 6 : 1, CDM_OP_SEG_LOAD, CDM_XOP_NONE, 1'b1);
			send({8'h8C, 8'hD8});
			check_exec(1, CDM_OP_SEG_STORE, CDM_XOP_NONE, 1'b1);
			// slow fetch: idle cycles between the bytes of one instruction
			fetch.gap = 2;
			send({8'h0F, 8'h22, 8'hC0});
			check_exec(m ? 18 : 20, CDM_OP_CTRL_WR, CDM_XOP_NONE, 1'b1);
			send({8'h0F, 8'h22, 8'hD8});
			check_exec(5, CDM_OP_CTRL_WR, CDM_XOP_NONE, 1'b1);
			send({8'h0F, 8'h22, 8'hE0});
			check_exec(m ? 6 : 5, CDM_OP_CTRL_WR, CDM_XOP_NONE, 1'b1);
			send({8'h0F, 8'h20, 8'hC0});
			check_exec(6, CDM_OP_CTRL_RD, CDM_XOP_NONE, 1'b1);
			fetch.gap = 0;
		end
	endtask
	task automatic sc_widen_product();
		send({8'h0F, 8'hBF, 8'hC0});
		send({8'h0F, 8'hBE, 8'hC1});
		check_exec(1, CDM_OP_NONE, CDM_XOP_SIGN_WIDEN, 1'b1);
		check_exec(1, CDM_OP_NONE, CDM_XOP_SIGN_WIDEN, 1'b1);
		send({8'h0F, 8'hB6, 8'hC0});
		send({8'h0F, 8'hB7, 8'hC1});
		check_exec(1, CDM_OP_NONE, CDM_XOP_ZERO_WIDEN, 1'b1);
		check_exec(1, CDM_OP_NONE, CDM_XOP_ZERO_WIDEN, 1'b1);
		send({8'hF6, 8'hE0});
		check_exec(4, CDM_OP_NONE, CDM_XOP_PRODUCT, 1'b0);
		send({8'hF7, 8'hE1});
		check_exec(5, CDM_OP_NONE, CDM_XOP_PRODUCT, 1'b0);
		opsize32 = 1'b1;
		send({8'hF7, 8'hE1});
		check_exec(15, CDM_OP_NONE, CDM_XOP_PRODUCT, 1'b0);
		opsize32 = 1'b0;
	endtask
	task automatic sc_debug_test();
		send({8'h0F, 8'h23, 8'hC0});
		send({8'h0F, 8'h21, 8'hC0});
		check_exec(10, CDM_OP_DBG_WR, CDM_XOP_NONE, 1'b1);
		check_exec(9, CDM_OP_DBG_RD, CDM_XOP_NONE, 1'b1);
		send({8'h0F, 8'h26, 8'hD8});
		send({8'h0F, 8'h24, 8'hD8});
		check_exec(16, CDM_OP_TEST_WR, CDM_XOP_NONE, 1'b1);
		check_exec(8, CDM_OP_TEST_RD, CDM_XOP_NONE, 1'b1);
		send({8'h0F, 8'h26, 8'hF0});
		send({8'h0F, 8'h24, 8'hF0});
		check_exec(11, CDM_OP_TEST_WR, CDM_XOP_NONE, 1'b1);
		check_exec(3, CDM_OP_TEST_RD, CDM_XOP_NONE, 1'b1);
		// refused encodings raise illegal; the control write runs one clock, the product its table count
		send({8'h0F, 8'h22, 8'hC8});
		check_exec(1, CDM_OP_CTRL_WR, CDM_XOP_NONE, 1'b1, 1'b1);
		send({8'hF6, 8'hC0});
		check_exec(4, CDM_OP_NONE, CDM_XOP_PRODUCT, 1'b0, 1'b1);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (20) @(negedge clk_sys);
		rst_n = 1'b1;
		check_val("idle ready", 8'h01, {7'h00, byte_ready});
		sc_teardown_branch();
		sc_short_forms();
		sc_segment_control();
		sc_widen_product();
		sc_debug_test();
		complete_run();
	end
endmodule
`default_nettype wire
